/* File: common/tpfa_cfg.svh */
// constants for the triple port fifo with access control and flags
// assumes one system clock; port clocks arrive as synchronous level inputs
`ifndef TPFA_CFG_SVH
`define TPFA_CFG_SVH

// ****************************************
// sizes
// ****************************************
`define TPFA_DEPTH      256
`define TPFA_WIDTH      18
`define TPFA_A_WIDTH    36
`define TPFA_BUF_DEPTH  2

// ****************************************
// flag values held in reset
// ****************************************
`define TPFA_RST_EMPTY_OR_READY  1'b0
`define TPFA_RST_ALMOST_EMPTY_N  1'b0
`define TPFA_RST_FULL_OR_INREADY 1'b1
`define TPFA_RST_ALMOST_FULL_N   1'b1

`endif

/* File: common/tpfa_pkg.sv */
// types for the triple port fifo block
// assumes tpfa_cfg.svh supplies the numeric constants
package tpfa_pkg;
	typedef enum logic {
		TPFA_STANDARD = 1'b0,
		TPFA_FALL_THROUGH_MODE     = 1'b1
	} tpfa_mode_t;
endpackage

/* File: hw/tpfa_top.sv */
// two fifos between a wide bidirectional port a and narrow ports b (read) and c (write)
// assumes port clocks and controls are synchronous to clk_sys and slower than it
//
// How it works
// - port c edge stores word in fifo two, or mail two when mail selected
// - port c fifo write needs input ready; no action while write enable is low
// - port a fifo one write needs select low, direction write, enable, no mail, ready
// - port a fifo two read needs select low, direction read, enable, no mail, ready
// - port b data driven while port b select low, released while high
// - port b fifo one read needs select low, read enable, no mail, ready
// - each port works independently of the other two
// - fall through, ready low: next word loads on the edge raising ready
// - fall through, ready high: output advances only on a selected read
// - standard mode never loads output unrequested; first word raises empty on edge two
// - every flag passes through at least two port clocked stages
// - each flag is timed by the port clock of the port that uses it
// - fall through ready high means new data; low keeps old word, reads ignored
// - standard empty high means readable data; low keeps old word, reads ignored
// - read pointer steps on every fifo word load of the output register, not on a mail read
// - fall through ready rises and loads the word on third read edge
// - standard empty flag rises on second read edge, only then reads allowed
// - a read edge in the same system cycle as the write, or in the next one, is not counted
// - fifo one flags follow word count against depth and thresholds
// - fifo one low and high thresholds are taken while in reset
// - the output register word is not counted in memory
// - a word moved to the output register frees its memory slot
// - dual flags act as ready in fall through mode, empty or full otherwise
// - full flag low means no space and writes ignored; high means space
`timescale 1ns/1ps
`include "tpfa_cfg.svh"

module tpfa_top #(
	parameter int DEPTH = `TPFA_DEPTH,
	parameter int W     = `TPFA_WIDTH,
	parameter int AWD   = `TPFA_A_WIDTH,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic                  fall_through_mode,
	input  wire logic [AW-1:0]         q1_low_threshold,
	input  wire logic [AW-1:0]         q1_high_threshold,
	input  wire logic [AW-1:0]         q2_low_threshold,
	input  wire logic [AW-1:0]         q2_high_threshold,
	input  wire logic                  porta_clk,
	input  wire logic                  porta_select_n,
	input  wire logic                  porta_dir_write,
	input  wire logic                  porta_xfer_en,
	input  wire logic                  porta_mail_sel,
	input  wire logic [AWD-1:0]        porta_data_in,
	output logic      [AWD-1:0]        porta_data_out,
	output logic                       porta_data_oe,
	output logic                       porta_empty_or_ready,
	output logic                       porta_almost_empty_n,
	output logic                       porta_full_or_inready,
	output logic                       porta_almost_full_n,
	input  wire logic                  portb_clk,
	input  wire logic                  portb_select_n,
	input  wire logic                  portb_read_en,
	input  wire logic                  portb_mail_sel,
	output logic      [W-1:0]          portb_data,
	output logic                       portb_data_oe,
	output logic                       portb_empty_or_ready,
	output logic                       portb_almost_empty_n,
	input  wire logic                  portc_clk,
	input  wire logic                  portc_write_en,
	input  wire logic                  portc_mail_sel,
	input  wire logic [W-1:0]          portc_data,
	output logic                       portc_full_or_inready,
	output logic                       portc_almost_full_n
);
	import tpfa_pkg::*;

	localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
	localparam logic [1:0]  BUF_MAX = 2'(`TPFA_BUF_DEPTH);

	// ****************************************
	// port clock edges and pad enables
	// ****************************************
	logic [2:0] clk_prev;
	logic [2:0] next_clk_prev;
	logic [2:0] edge_seen;
	logic       next_a_oe;
	logic       next_b_oe;

	always_comb begin
		next_clk_prev = {portc_clk, portb_clk, porta_clk};
		// an edge is the system cycle where the port clock is first seen high
		edge_seen = next_clk_prev & ~clk_prev;
		next_a_oe = ~porta_select_n & ~porta_dir_write;
		next_b_oe = ~portb_select_n;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			clk_prev      <= 3'h0;
			porta_data_oe <= 1'b0;
			portb_data_oe <= 1'b0;
		end else begin
			clk_prev      <= next_clk_prev;
			porta_data_oe <= next_a_oe;
			portb_data_oe <= next_b_oe;
		end
	end

	// ****************************************
	// per fifo request routing (0 = a to b, 1 = c to a)
	// ****************************************
	logic [1:0]   wr_edge;
	logic [1:0]   wr_sel;
	logic [1:0]   wr_mail;
	logic [1:0]   rd_edge;
	logic [1:0]   rd_sel;
	logic [1:0]   rd_mail;
	logic [W-1:0] wr_data [2];
	logic [W-1:0] dout    [2];
	logic [1:0]   ef_or;
	logic [1:0]   ae_n;
	logic [1:0]   ff_ir;
	logic [1:0]   af_n;
	logic [AW-1:0] low_thr_in  [2];
	logic [AW-1:0] high_thr_in [2];

	always_comb begin
		wr_edge    = {edge_seen[2], edge_seen[0]};
		wr_sel[0]  = ~porta_select_n & porta_dir_write & porta_xfer_en;
		wr_sel[1]  = portc_write_en;
		wr_mail    = {portc_mail_sel, porta_mail_sel};
		wr_data[0] = porta_data_in[W-1:0];
		wr_data[1] = portc_data;
		rd_edge    = {edge_seen[0], edge_seen[1]};
		rd_sel[0]  = ~portb_select_n & portb_read_en;
		rd_sel[1]  = ~porta_select_n & ~porta_dir_write & porta_xfer_en;
		rd_mail    = {porta_mail_sel, portb_mail_sel};
		low_thr_in[0]  = q1_low_threshold;
		low_thr_in[1]  = q2_low_threshold;
		high_thr_in[0] = q1_high_threshold;
		high_thr_in[1] = q2_high_threshold;
	end

	// ****************************************
	// the two fifos, each running on its own port edges
	// ****************************************
	for (genvar f = 0; f < 2; f++) begin : g_fifo
		// ****************************************
		// storage and straps
		// ****************************************
		logic [W-1:0]  mem [DEPTH];
		logic [W-1:0]  bufm [`TPFA_BUF_DEPTH];
		logic [AW:0]   low_thr;
		logic [AW:0]   high_thr;
		tpfa_mode_t    mode;

		// ****************************************
		// write side state
		// ****************************************
		logic          bhead;
		logic [1:0]    bcnt;
		logic [AW:0]   wtot;
		logic [AW:0]   wptr;
		logic [AW:0]   rsync1;
		logic [W-1:0]  mail;
		logic          next_bhead;
		logic [1:0]    next_bcnt;
		logic [AW:0]   next_wtot;
		logic [AW:0]   next_wptr;
		logic [AW:0]   next_rsync1;
		logic [W-1:0]  next_mail;
		logic          next_ff;
		logic          next_af;
		logic          wr_take;
		logic          mail_take;
		logic          buf_room;
		logic          push;
		logic          pop;
		logic [AW:0]   wr_cnt;

		// ****************************************
		// read side state
		// ****************************************
		logic [AW:0]   rptr;
		logic [AW:0]   wsync1;
		logic [AW:0]   wsync2;
		logic [AW:0]   next_rptr;
		logic [AW:0]   next_wsync1;
		logic [AW:0]   next_wsync2;
		logic [W-1:0]  next_dout;
		logic          next_ef;
		logic          next_ae;
		logic          fifo_rd;
		logic          mail_rd;
		logic          load;
		logic [AW:0]   rd_cnt;

		// ****************************************
		// write side
		// ****************************************
		always_comb begin
			wr_take   = wr_edge[f] & wr_sel[f] & ~wr_mail[f];
			mail_take = wr_edge[f] & wr_sel[f] & wr_mail[f];
			// the buffer room term drops the write while both buffer slots are taken
			buf_room  = (bcnt != BUF_MAX);
			push      = wr_take & ff_ir[f] & buf_room;
			pop       = (bcnt != 2'h0) & ((wptr - rptr) < DEPTH_W);
			next_mail = mail;
			if (mail_take) begin
				next_mail = wr_data[f];
			end
			next_wtot  = wtot + (AW+1)'(push);
			next_wptr  = wptr + (AW+1)'(pop);
			next_bhead = bhead ^ pop;
			next_bcnt  = bcnt + 2'(push) - 2'(pop);

			next_rsync1 = rsync1;
			next_ff     = ff_ir[f];
			next_af     = af_n[f];
			// buffered words count too, so a full flag never overbooks memory
			wr_cnt = next_wtot - rsync1;
			if (wr_edge[f]) begin
				next_rsync1 = rptr;
				next_ff = (wr_cnt < DEPTH_W);
				next_af = (wr_cnt < (DEPTH_W - high_thr));
			end
		end

		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				bhead    <= 1'b0;
				bcnt     <= 2'h0;
				wtot     <= '0;
				wptr     <= '0;
				rsync1   <= '0;
				mail     <= '0;
				ff_ir[f] <= `TPFA_RST_FULL_OR_INREADY;
				af_n[f]  <= `TPFA_RST_ALMOST_FULL_N;
			end else begin
				bhead    <= next_bhead;
				bcnt     <= next_bcnt;
				wtot     <= next_wtot;
				wptr     <= next_wptr;
				rsync1   <= next_rsync1;
				mail     <= next_mail;
				ff_ir[f] <= next_ff;
				af_n[f]  <= next_af;
			end
		end

		// ****************************************
		// read side
		// ****************************************
		always_comb begin
			fifo_rd = rd_edge[f] & rd_sel[f] & ~rd_mail[f];
			mail_rd = rd_edge[f] & rd_sel[f] & rd_mail[f];
			if (mode == TPFA_STANDARD) begin
				load = fifo_rd & ef_or[f];
			end else begin
				// third edge: wsync2 holds the write only after two earlier edges
				load = rd_edge[f] & (wsync2 != rptr)
					& (~ef_or[f] | (fifo_rd & ef_or[f]));
			end
			next_rptr = rptr + (AW+1)'(load);
			next_dout = dout[f];
			if (load) begin
				next_dout = mem[rptr[AW-1:0]];
			end else if (mail_rd) begin
				next_dout = mail;
			end

			next_wsync1 = wsync1;
			next_wsync2 = wsync2;
			next_ef     = ef_or[f];
			next_ae     = ae_n[f];
			rd_cnt      = wsync1 - next_rptr;
			if (rd_edge[f]) begin
				// the write lands in wptr two cycles after its edge, so a read edge in
				// the same cycle or the next one cannot see it
				next_wsync1 = wptr;
				next_wsync2 = wsync1;
				if (mode == TPFA_STANDARD) begin
					next_ef = (wsync1 != next_rptr);
				end else begin
					next_ef = load | (ef_or[f] & ~fifo_rd);
				end
				next_ae = (rd_cnt > low_thr);
			end
		end

		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				rptr     <= '0;
				wsync1   <= '0;
				wsync2   <= '0;
				dout[f]  <= '0;
				ef_or[f] <= `TPFA_RST_EMPTY_OR_READY;
				ae_n[f]  <= `TPFA_RST_ALMOST_EMPTY_N;
			end else begin
				rptr     <= next_rptr;
				wsync1   <= next_wsync1;
				wsync2   <= next_wsync2;
				dout[f]  <= next_dout;
				ef_or[f] <= next_ef;
				ae_n[f]  <= next_ae;
			end
		end

		// ****************************************
		// straps, held from the last reset cycle
		// ****************************************
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				// reset is synchronous, so straps are simply sampled while it is held
				mode     <= tpfa_mode_t'(fall_through_mode);
				low_thr  <= {1'b0, low_thr_in[f]};
				high_thr <= {1'b0, high_thr_in[f]};
			end
		end

		always_ff @(posedge clk_sys) begin
			if (push) begin
				bufm[bhead ^ bcnt[0]] <= wr_data[f];
			end
			if (pop) begin
				mem[wptr[AW-1:0]] <= bufm[bhead];
			end
		end
	end

	// ****************************************
	// pins, all straight from flops
	// ****************************************
	always_comb begin
		porta_data_out        = {{(AWD-W){1'b0}}, dout[1]};
		portb_data            = dout[0];
		porta_empty_or_ready  = ef_or[1];
		porta_almost_empty_n  = ae_n[1];
		porta_full_or_inready = ff_ir[0];
		porta_almost_full_n   = af_n[0];
		portb_empty_or_ready  = ef_or[0];
		portb_almost_empty_n  = ae_n[0];
		portc_full_or_inready = ff_ir[1];
		portc_almost_full_n   = af_n[1];
	end
endmodule

/* File: tb/tpfa_clk_src.sv */
// three port clock sources standing in for the bus masters
// assumes clk_sys and the shared synchronous reset
`timescale 1ns/1ps
module tpfa_clk_src #(
	parameter int PA = 3,
	parameter int PB = 6,
	parameter int PC = 5
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	output logic      porta_clk,
	output logic      portb_clk,
	output logic      portc_clk
);
	// free-running, one system cycle high; periods differ, but every port b edge falls with a port a edge
	int na, nb, nc;
	always_ff @(posedge clk_sys) begin
		na <= (sys_rst || na == 0) ? PA - 1 : na - 1;
		nb <= (sys_rst || nb == 0) ? PB - 1 : nb - 1;
		nc <= (sys_rst || nc == 0) ? PC - 1 : nc - 1;
	end
	assign porta_clk = !sys_rst && na == 0;
	assign portb_clk = !sys_rst && nb == 0;
	assign portc_clk = !sys_rst && nc == 0;
endmodule

/* File: tb/tpfa_props.sv */
// port level assertions for the fifo block
// assumes port clocks are levels sampled on clk_sys
`timescale 1ns/1ps
module tpfa_props #(
	parameter int W = 18
) (
	input wire logic         clk_sys,
	input wire logic         sys_rst,
	input wire logic         fall_through_mode,
	input wire logic         porta_clk,
	input wire logic         portb_clk,
	input wire logic         portc_clk,
	input wire logic         portb_select_n,
	input wire logic         portb_read_en,
	input wire logic         portb_mail_sel,
	input wire logic [W-1:0] portb_data,
	input wire logic         portb_data_oe,
	input wire logic         portb_empty_or_ready,
	input wire logic         portb_almost_empty_n,
	input wire logic         porta_empty_or_ready,
	input wire logic         porta_full_or_inready,
	input wire logic         porta_almost_full_n,
	input wire logic         portc_full_or_inready
);
	logic pa, pb, pc;
	always_ff @(posedge clk_sys) {pa, pb, pc} <= {porta_clk, portb_clk, portc_clk};
	wire ea = porta_clk && !pa;
	wire eb = portb_clk && !pb;
	wire ec = portc_clk && !pc;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_b_oe;
		$past(!sys_rst) |-> portb_data_oe == !$past(portb_select_n);
	endproperty
	a_b_oe: assert property (p_b_oe) else $error("b enable lag");
	property p_b_std;
		!fall_through_mode && $changed(portb_data)
			|-> $past(eb && !portb_select_n && portb_read_en);
	endproperty
	a_b_std: assert property (p_b_std) else $error("b load unasked");
	property p_b_hold;
		!fall_through_mode && $past(eb && !portb_empty_or_ready && !portb_mail_sel)
			|-> $stable(portb_data);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("b read while empty");
	property p_b_sync;
		$changed(portb_empty_or_ready) || $changed(portb_almost_empty_n) |-> $past(eb);
	endproperty
	a_b_sync: assert property (p_b_sync) else $error("b flag off edge");
	property p_a_sync;
		$changed(porta_empty_or_ready) || $changed(porta_full_or_inready)
			|| $changed(porta_almost_full_n) |-> $past(ea);
	endproperty
	a_a_sync: assert property (p_a_sync) else $error("a flag off edge");
	property p_c_sync;
		$changed(portc_full_or_inready) |-> $past(ec);
	endproperty
	a_c_sync: assert property (p_c_sync) else $error("c flag off edge");
	property p_b_ae;
		!fall_through_mode && portb_almost_empty_n |-> portb_empty_or_ready;
	endproperty
	a_b_ae: assert property (p_b_ae) else $error("b flags disagree");
	property p_a_full;
		!porta_full_or_inready |-> !porta_almost_full_n;
	endproperty
	a_a_full: assert property (p_a_full) else $error("a flags disagree");
endmodule

bind tpfa_top tpfa_props #(.W(W)) u_props (
	.clk_sys, .sys_rst, .fall_through_mode, .porta_clk, .portb_clk, .portc_clk,
	.portb_select_n, .portb_read_en, .portb_mail_sel, .portb_data, .portb_data_oe,
	.portb_empty_or_ready, .portb_almost_empty_n, .porta_empty_or_ready,
	.porta_full_or_inready, .porta_almost_full_n, .portc_full_or_inready
);

/* File: tb/triple_port_fifo_access_flags_test.sv */
// self-checking bench for the triple port fifo block
// assumes tpfa_clk_src supplies the port clocks
`timescale 1ns/1ps
module triple_port_fifo_access_flags_test;
	logic        clk_sys = 1'h0, sys_rst = 1'h1, fall_through_mode = 1'h0;
	logic        porta_select_n = 1'h1, porta_dir_write = 1'h0, porta_xfer_en = 1'h0;
	logic        porta_mail_sel = 1'h0, portb_select_n = 1'h1, portb_read_en = 1'h0;
	logic        portb_mail_sel = 1'h0, portc_write_en = 1'h0, portc_mail_sel = 1'h0;
	logic [35:0] porta_data_in = 36'h0, porta_data_out;
	logic [17:0] portc_data = 18'h0, portb_data;
	logic        porta_clk, portb_clk, portc_clk, porta_data_oe, porta_empty_or_ready;
	logic        porta_almost_empty_n, porta_full_or_inready, porta_almost_full_n;
	logic        portb_data_oe, portb_empty_or_ready, portb_almost_empty_n, bprev = 1'h0;
	logic        portc_full_or_inready, portc_almost_full_n;
	int          failures = 0, num_checks = 0, cyc = 0, wmark = 0, bcnt = 0;
	wire [2:0]   pck = {portc_clk, portb_clk, porta_clk};

	tpfa_clk_src u_clks (.clk_sys, .sys_rst, .porta_clk, .portb_clk, .portc_clk);
	tpfa_top u_dut (
		.clk_sys, .sys_rst, .fall_through_mode, .q1_low_threshold(8'h02),
		.q1_high_threshold(8'h04), .q2_low_threshold(8'h02), .q2_high_threshold(8'h04),
		.porta_clk, .porta_select_n, .porta_dir_write, .porta_xfer_en, .porta_mail_sel,
		.porta_data_in, .porta_data_out, .porta_data_oe, .porta_empty_or_ready,
		.porta_almost_empty_n, .porta_full_or_inready, .porta_almost_full_n, .portb_clk,
		.portb_select_n, .portb_read_en, .portb_mail_sel, .portb_data, .portb_data_oe,
		.portb_empty_or_ready, .portb_almost_empty_n, .portc_clk, .portc_write_en,
		.portc_mail_sel, .portc_data, .portc_full_or_inready, .portc_almost_full_n
	);

	initial forever #20 clk_sys = ~clk_sys;
	// counts port b edges that fall two or more cycles after the marked write
	always @(posedge clk_sys) begin
		if (portb_clk && !bprev && cyc >= wmark + 2) begin
			bcnt <= bcnt + 1;
		end
		bprev <= portb_clk;
		cyc <= cyc + 1;
	end

	// ****
	// tasks
	// ****
	task automatic end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
		end
	endtask
	// returns just after a port clock goes high; drives made now meet its edge
	task automatic tick(input int p);
		for (int k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			#1;
			if (pck[p]) return;
		end
		failures++;
		end_of_test();
	endtask
	task automatic wait_rdy(input int p);
		for (int k = 0; k < 200; k++) begin
			@(posedge clk_sys);
			#1;
			if ((p == 1 ? portb_empty_or_ready : porta_empty_or_ready) === 1'h1) return;
		end
		failures++;
		end_of_test();
	endtask
	task automatic a_op(input logic en, input logic wr, input logic [35:0] d);
		tick(0);
		porta_xfer_en = en;
		porta_dir_write = wr;
		porta_data_in = d;
		if (en) begin
			wmark = cyc;
			bcnt = 0;
		end
	endtask
	task automatic b_op(input logic en);
		tick(1);
		portb_read_en = en;
	endtask
	task automatic c_op(input logic en, input logic mail, input logic [17:0] d);
		tick(2);
		portc_write_en = en;
		portc_mail_sel = mail;
		portc_data = d;
	endtask

	// ****
	// tests
	// ****
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		sys_rst = 1'h0;
		chk_flag(portb_data_oe, 1'h0);
		chk_flag(portc_full_or_inready, 1'h1);
		chk_flag(portc_almost_full_n, 1'h1);
		chk_flag(porta_almost_empty_n, 1'h0);
		porta_select_n = 1'h0;
		portb_select_n = 1'h0;
		tick(1);
		a_op(1'h1, 1'h1, 36'h100);
		a_op(1'h0, 1'h1, 36'h0);
		wait_rdy(1);
		chk_word(36'(bcnt), 36'h2);
		chk_word({18'h0, portb_data}, 36'h0);
		chk_flag(portb_data_oe, 1'h1);
		for (int i = 1; i <= 256; i++) begin
			a_op(1'h1, 1'h1, 36'h100 + 36'(i));
			chk_flag(porta_almost_full_n, i < 252);
			chk_flag(porta_full_or_inready, i < 256);
		end
		a_op(1'h0, 1'h1, 36'h0);
		chk_flag(portb_almost_empty_n, 1'h1);
		for (int i = 0; i < 256; i++) begin
			b_op(1'h1);
			if (i > 0) chk_word({18'h0, portb_data}, 36'h100 + 36'(i - 1));
			if (i > 0) chk_flag(portb_almost_empty_n, 256 - i > 2);
		end
		b_op(1'h0);
		chk_flag(portb_empty_or_ready, 1'h0);
		b_op(1'h1);
		b_op(1'h0);
		chk_word({18'h0, portb_data}, 36'h1ff);
		chk_flag(porta_full_or_inready, 1'h1);
		$display("standard fifo one test done");
		a_op(1'h0, 1'h0, 36'h0);
		c_op(1'h0, 1'h0, 18'h3a);
		c_op(1'h1, 1'h1, 18'h3b);
		c_op(1'h1, 1'h0, 18'h3c);
		c_op(1'h0, 1'h0, 18'h0);
		wait_rdy(0);
		chk_flag(porta_data_oe, 1'h1);
		chk_flag(porta_almost_empty_n, 1'h0);
		chk_flag(portc_full_or_inready, 1'h1);
		chk_flag(portc_almost_full_n, 1'h1);
		a_op(1'h1, 1'h0, 36'h0);
		a_op(1'h0, 1'h0, 36'h0);
		chk_word(porta_data_out, 36'h3c);
		chk_flag(porta_empty_or_ready, 1'h0);
		porta_mail_sel = 1'h1;
		a_op(1'h1, 1'h0, 36'h0);
		a_op(1'h0, 1'h0, 36'h0);
		porta_mail_sel = 1'h0;
		chk_word(porta_data_out, 36'h3b);
		$display("standard fifo two test done");
		sys_rst = 1'h1;
		fall_through_mode = 1'h1;
		repeat (2) @(posedge clk_sys);
		#1;
		sys_rst = 1'h0;
		tick(1);
		a_op(1'h1, 1'h1, 36'h11);
		a_op(1'h0, 1'h1, 36'h0);
		wait_rdy(1);
		chk_word(36'(bcnt), 36'h3);
		chk_word({18'h0, portb_data}, 36'h11);
		a_op(1'h1, 1'h1, 36'h22);
		a_op(1'h0, 1'h1, 36'h0);
		repeat (3) tick(1);
		chk_word({18'h0, portb_data}, 36'h11);
		b_op(1'h1);
		b_op(1'h1);
		b_op(1'h0);
		chk_word({18'h0, portb_data}, 36'h22);
		chk_flag(portb_empty_or_ready, 1'h0);
		b_op(1'h1);
		b_op(1'h0);
		chk_word({18'h0, portb_data}, 36'h22);
		$display("fall through test done");
		end_of_test();
	end
endmodule
